// file: common/sfc_pkg.sv
// sfc_pkg: constants shared by the serial fifo control block and its fifo and buffer.
// assumes a single 125 MHz clock and a control port with one word select bit.
`default_nettype none
package sfc_pkg;

  // clock
  localparam int unsigned CLK_HZ = 125_000_000;

  // register selects on the control port
  localparam logic REG_CONTROL = 1'b0;
  localparam logic REG_COUNT = 1'b1;

  // fifo control register fields
  localparam int unsigned CTL_LOOP_BIT = 0;
  localparam int unsigned CTL_RX_FLUSH_BIT = 1;
  localparam int unsigned CTL_TX_FLUSH_BIT = 2;
  localparam int unsigned CTL_FLOW_BIT = 3;
  localparam int unsigned CTL_TX_TRIG_LSB = 4;
  localparam int unsigned CTL_RX_TRIG_LSB = 6;
  localparam int unsigned CTL_W = 8;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK_FULL = 8'hff;
  localparam logic [7:0] CTL_WMASK_NOFLOW = 8'hf7;

  // occupancy count register fields
  localparam int unsigned CNT_W = 5;
  localparam int unsigned CNT_TX_LSB = 8;
  localparam int unsigned CNT_RX_LSB = 0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // fifo shape
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned DATA_W = 8;

  // receive trigger levels, four 5-bit entries, entry 0 in the low bits
  localparam logic [19:0] RX_TRIG_ASYNC = {5'h0e, 5'h08, 5'h04, 5'h01};
  localparam logic [19:0] RX_TRIG_SYNC = {5'h0e, 5'h08, 5'h02, 5'h01};

  // receive occupancy at which rts is deasserted under flow control
  localparam logic [4:0] RTS_LEVEL_DEF = 5'h0f;

  // pin levels after reset: cts deasserted, line at mark
  localparam logic [1:0] PIN_SYNC_RESET = 2'h3;

endpackage : sfc_pkg
`default_nettype wire

// file: common/sfc_stream_if.sv
// sfc_stream_if: valid/ready word stream between fifo, buffer and top.
// assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface sfc_stream_if #(
  parameter int unsigned W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfc_stream_if
`default_nettype wire

// file: rtl/sfc_fifo.sv
// sfc_fifo: word fifo with a registered head word and flush.
// assumes flush is a level from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic flush, // level, empties the fifo while high
  input wire logic in_valid, // word offered
  output logic in_ready, // word taken when both high
  input wire logic [W-1:0] in_data, // word in
  sfc_stream_if.src out, // head word
  output logic [$clog2(DEPTH+1)-1:0] count // words held, head included
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sfc_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] mem_cnt_r;
  logic head_valid_r;
  logic [W-1:0] head_data_r;
  wire push;
  wire pop_mem;

  // occupancy counts the head register too, so full means DEPTH words total
  assign count = CW'(mem_cnt_r + {{(CW-1){1'b0}}, head_valid_r});
  assign in_ready = !flush && (count < CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop_mem = (mem_cnt_r != '0) && (!head_valid_r || out.ready) && !flush;
  assign out.valid = head_valid_r;
  assign out.data = head_data_r;

  // storage, no reset needed since count guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count; flush and reset both empty the fifo
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      mem_cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      if (pop_mem) rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      case ({push, pop_mem})
        2'b10: mem_cnt_r <= CW'(mem_cnt_r + 1'b1);
        2'b01: mem_cnt_r <= CW'(mem_cnt_r - 1'b1);
        default: mem_cnt_r <= mem_cnt_r;
      endcase
    end
  end

  // head word is read out of memory into a register
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      head_valid_r <= 1'b0;
      head_data_r <= '0;
    end else if (pop_mem) begin
      head_valid_r <= 1'b1;
      head_data_r <= mem[rd_ptr_r];
    end else if (out.ready) begin
      head_valid_r <= 1'b0;
    end
  end
endmodule : sfc_fifo
`default_nettype wire

// file: rtl/sfc_serial_fifo_ctrl.sv
// sfc_serial_fifo_ctrl: fifo control and occupancy count for one serial channel.
// assumes a shifter on tx_out/tx_serial and rx_in/rx_serial, pins on the far side.
//
// Overview of operation
// - flow enable bit 3 makes cts gate sending and rts signal receive room.
// - third channel: flow enable bit reads 0, software writes only 0.
// - flow disabled: cts taken as asserted low, rts held at 0.
// - transmit flush bit 2 high discards transmit words and holds fifo empty.
// - receive flush bit 1 high discards received words and holds fifo empty.
// - reset empties both fifos though both flush bits reset to 0.
// - loop bit 0 feeds transmit serial output back into receive input.
// - count register: transmit occupancy bits 12..8, receive bits 4..0.
// - transmit field reads 0x00 when empty, 0x10 when full.
// - receive field reads 0x00 when empty, 0x10 when full.
// - reset sets the whole count register to 0x0000.
// - count bits 15..13 and 7..5 read 0; software writes zeros there.
// - count register always readable; writes do not change it.
// - receive level flag set when occupancy exceeds the selected trigger level.
`timescale 1ns/1ns
`default_nettype none
module sfc_serial_fifo_ctrl #(
  parameter int unsigned DEPTH = sfc_pkg::FIFO_DEPTH,
  parameter int unsigned W = sfc_pkg::DATA_W,
  parameter logic THIRD_CHANNEL = 1'b0,
  parameter logic [4:0] RTS_LEVEL = sfc_pkg::RTS_LEVEL_DEF
) (
  input wire logic ref_clk, // 125 MHz block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sync_mode, // level, channel in clocked synchronous operation
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic reg_rd, // one-cycle read strobe
  input wire logic reg_addr, // register select
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, valid the cycle after reg_rd
  input wire logic tx_in_valid, // cpu offers a transmit word
  output logic tx_in_ready, // transmit fifo takes it
  input wire logic [W-1:0] tx_in_data, // transmit word
  output logic tx_out_valid, // word for the transmit shifter
  input wire logic tx_out_ready, // transmit shifter takes it
  output logic [W-1:0] tx_out_data, // word for the transmit shifter
  input wire logic tx_serial, // serial stream from the transmit shifter
  input wire logic rx_in_valid, // receive shifter offers a word
  output logic rx_in_ready, // receive fifo takes it
  input wire logic [W-1:0] rx_in_data, // received word
  output logic rx_out_valid, // received word for the cpu
  input wire logic rx_out_ready, // cpu takes it
  output logic [W-1:0] rx_out_data, // received word for the cpu
  output logic rx_serial, // serial stream to the receive shifter
  output logic txd_pin, // transmit data pin
  input wire logic rxd_pin, // receive data pin, asynchronous
  input wire logic cts_n_pin, // clear to send pin, active low, asynchronous
  output logic rts_n_pin, // request to send pin, active low
  output logic rx_level_reached_flag // level, receive occupancy above trigger level
);
  localparam int unsigned CW = $clog2(DEPTH+1);

  if (DEPTH > 16 || CW > sfc_pkg::CNT_W) begin : g_bad_depth
    $error("sfc_serial_fifo_ctrl depth must fit the 5-bit count fields");
  end
  if (RTS_LEVEL > DEPTH || RTS_LEVEL == 5'h00) begin : g_bad_rts
    $error("sfc_serial_fifo_ctrl rts level must lie in 1..DEPTH");
  end

  // control register and its fields
  logic [7:0] ctl_r;
  wire loop_on;
  wire rx_flush;
  wire tx_flush;
  wire flow_on;
  wire [1:0] rx_trig_sel;
  wire [7:0] ctl_wmask;
  wire [7:0] ctl_view;

  // pin synchronisers: bit 1 cts, bit 0 rxd
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_filt_r;
  wire [1:0] pin_agree;
  wire [1:0] pin_filt_nxt;
  wire cts_n_eff;
  wire cts_ok;

  // occupancy and flags
  wire [CW-1:0] tx_cnt;
  wire [CW-1:0] rx_cnt;
  wire [4:0] tx_cnt5;
  wire [4:0] rx_cnt5;
  wire [15:0] count_view;
  wire [4:0] lvl_async;
  wire [4:0] lvl_sync;
  wire [4:0] rx_lvl;
  wire rts_n_nxt;
  logic rts_n_r;
  logic rx_flag_r;
  logic [15:0] rdata_r;
  logic txd_r;
  logic rx_serial_r;
  wire [15:0] rdata_nxt;

  sfc_stream_if #(.W(W)) tx_mid ();
  sfc_stream_if #(.W(W)) tx_buf ();
  sfc_stream_if #(.W(W)) rx_mid ();
  sfc_stream_if #(.W(W)) rx_buf ();

  // control fields; the third channel has no flow control, so its bit is masked
  assign loop_on = ctl_r[sfc_pkg::CTL_LOOP_BIT];
  assign rx_flush = ctl_r[sfc_pkg::CTL_RX_FLUSH_BIT];
  assign tx_flush = ctl_r[sfc_pkg::CTL_TX_FLUSH_BIT];
  assign flow_on = ctl_r[sfc_pkg::CTL_FLOW_BIT];
  assign rx_trig_sel = ctl_r[sfc_pkg::CTL_RX_TRIG_LSB +: 2];
  assign ctl_wmask = THIRD_CHANNEL ? sfc_pkg::CTL_WMASK_NOFLOW : sfc_pkg::CTL_WMASK_FULL;
  assign ctl_view = ctl_r & ctl_wmask;

  // control register write; reset leaves every control bit at 0
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl_r <= sfc_pkg::CTL_RESET;
    end else if (reg_wr && reg_addr == sfc_pkg::REG_CONTROL) begin
      ctl_r <= reg_wdata[7:0] & ctl_wmask;
    end
  end

  // three-stage pin capture; a change counts once stages two and three agree
  assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
  assign pin_filt_nxt = (pin_s3_r & pin_agree) | (pin_filt_r & ~pin_agree);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_r <= sfc_pkg::PIN_SYNC_RESET;
      pin_s2_r <= sfc_pkg::PIN_SYNC_RESET;
      pin_s3_r <= sfc_pkg::PIN_SYNC_RESET;
      pin_filt_r <= sfc_pkg::PIN_SYNC_RESET;
    end else begin
      pin_s1_r <= {cts_n_pin, rxd_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_filt_r <= pin_filt_nxt;
    end
  end

  // with flow control off cts is taken as asserted whatever the pin says
  assign cts_n_eff = flow_on ? pin_filt_r[1] : 1'b0;
  assign cts_ok = !cts_n_eff;

  // transmit path: cpu -> fifo -> buffer -> shifter, flushed by its own bit
  sfc_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(tx_flush),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in_data),
    .out(tx_mid),
    .count(tx_cnt)
  );

  sfc_skid #(.W(W)) u_tx_skid (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(tx_flush),
    .in(tx_mid),
    .out(tx_buf)
  );

  // a deasserted cts stalls the shifter side; the word waits in the buffer
  assign tx_out_valid = tx_buf.valid && cts_ok;
  assign tx_buf.ready = tx_out_ready && cts_ok;
  assign tx_out_data = tx_buf.data;

  // receive path: shifter -> fifo -> buffer -> cpu
  sfc_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(rx_flush),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_data),
    .out(rx_mid),
    .count(rx_cnt)
  );

  sfc_skid #(.W(W)) u_rx_skid (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(rx_flush),
    .in(rx_mid),
    .out(rx_buf)
  );

  assign rx_out_valid = rx_buf.valid;
  assign rx_buf.ready = rx_out_ready;
  assign rx_out_data = rx_buf.data;

  // occupancy fields; words in the output buffers have left the fifo already
  assign tx_cnt5 = 5'(tx_cnt);
  assign rx_cnt5 = 5'(rx_cnt);
  assign count_view = {3'h0, tx_cnt5, 3'h0, rx_cnt5};

  // receive trigger level, table chosen by mode
  assign lvl_async = sfc_pkg::RX_TRIG_ASYNC[int'(rx_trig_sel) * 5 +: 5];
  assign lvl_sync = sfc_pkg::RX_TRIG_SYNC[int'(rx_trig_sel) * 5 +: 5];
  assign rx_lvl = sync_mode ? lvl_sync : lvl_async;

  // rts deasserts near full so the remote station stops before overrun
  assign rts_n_nxt = flow_on ? (rx_cnt5 >= RTS_LEVEL) : 1'b0;

  // registered pins and flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rts_n_r <= 1'b0;
      rx_flag_r <= 1'b0;
    end else begin
      rts_n_r <= rts_n_nxt;
      rx_flag_r <= (rx_cnt5 > rx_lvl);
    end
  end

  // loop-back keeps the pin at mark so the line sees no test traffic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txd_r <= 1'b1;
      rx_serial_r <= 1'b1;
    end else begin
      txd_r <= loop_on ? 1'b1 : tx_serial;
      rx_serial_r <= loop_on ? tx_serial : pin_filt_r[0];
    end
  end

  // register read; count has no write path at all
  assign rdata_nxt = (reg_addr == sfc_pkg::REG_COUNT) ? count_view : {8'h00, ctl_view};
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_r <= sfc_pkg::COUNT_RESET;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign rts_n_pin = rts_n_r;
  assign rx_level_reached_flag = rx_flag_r;
  assign txd_pin = txd_r;
  assign rx_serial = rx_serial_r;
endmodule : sfc_serial_fifo_ctrl
`default_nettype wire

// file: rtl/sfc_skid.sv
// sfc_skid: two-entry buffer so a stalled receiver loses no word.
// assumes flush is a level from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfc_skid #(
  parameter int unsigned W = 8
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic flush, // level, drops both entries
  sfc_stream_if.snk in, // words from the fifo
  sfc_stream_if.src out // words to the consumer
);
  logic [1:0] cnt_r;
  logic [W-1:0] data0_r;
  logic [W-1:0] data1_r;
  wire push;
  wire pop;

  // ready looks only at the own count and flush, so no path from out.ready to in.ready
  assign in.ready = (cnt_r != 2'h2) && !flush;
  assign out.valid = (cnt_r != 2'h0);
  assign out.data = data0_r;
  assign push = in.valid && in.ready;
  assign pop = out.valid && out.ready;

  // entry 0 is always the oldest word
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      cnt_r <= 2'h0;
      data0_r <= '0;
      data1_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) data0_r <= in.data;
          else data1_r <= in.data;
          cnt_r <= 2'(cnt_r + 1'b1);
        end
        2'b01: begin
          data0_r <= data1_r;
          cnt_r <= 2'(cnt_r - 1'b1);
        end
        2'b11: begin
          if (cnt_r == 2'h1) begin
            data0_r <= in.data;
          end else begin
            data0_r <= data1_r;
            data1_r <= in.data;
          end
        end
        default: cnt_r <= cnt_r;
      endcase
    end
  end
endmodule : sfc_skid
`default_nettype wire

// file: verif/sfc_remote_station.sv
// sfc_remote_station: far-end station on the serial pins, rts/cts flow control.
// assumes the bench commands when it is busy and the line level it sends.
`timescale 1ns/1ns
`default_nettype none
module sfc_remote_station (
  input wire logic ref_clk, // bench clock
  input wire logic busy, // bench command, station cannot take words
  input wire logic line_bit, // bench command, level to send
  input wire logic rts_n_pin, // high: device asks us to stop
  output logic cts_n_pin, // our clear to send, active low
  output logic rxd_pin // our line into the device
);
  logic busy_r = 1'b1;
  logic line_r = 1'b1;
  // registered like a real station, so the device sees a clean edge
  always @(posedge ref_clk) begin
    busy_r <= busy;
    line_r <= rts_n_pin ? 1'b1 : line_bit;
  end
  assign cts_n_pin = busy_r;
  assign rxd_pin = line_r;
endmodule : sfc_remote_station
`default_nettype wire

// file: verif/sfc_serial_fifo_ctrl_monitor.sv
// sfc_serial_fifo_ctrl_monitor: port-level checks of the fifo control block.
// assumes it is bound into sfc_serial_fifo_ctrl, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfc_serial_fifo_ctrl_monitor (
  input wire logic ref_clk, // block clock
  input wire logic rst_n, // reset, active low
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic reg_addr, // register select
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata, // read data
  input wire logic tx_in_ready, // tx fifo ready
  input wire logic tx_out_valid, // tx word offered
  input wire logic rx_in_ready, // rx fifo ready
  input wire logic rx_out_valid, // rx word offered
  input wire logic tx_serial, // shifter stream
  input wire logic rx_serial, // stream to rx shifter
  input wire logic txd_pin, // tx pin
  input wire logic cts_n_pin, // cts pin
  input wire logic rts_n_pin // rts pin
);
  logic [3:0] ctl_r;
  // shadow of control bits 3..0, built from writes only, never from outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) ctl_r <= 4'h0;
    else if (reg_wr && reg_addr == sfc_pkg::REG_CONTROL) ctl_r <= reg_wdata[3:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cts held off with flow enabled; pin filter needs a few edges
  sequence s_cts_off;
    ctl_r[3] && cts_n_pin;
  endsequence
  sequence s_loop_on;
    ctl_r[0] [*2];
  endsequence
  chk_reset_clears: assert property ($rose(rst_n) |-> reg_rdata == 16'h0000
    && !rts_n_pin && !tx_out_valid && !rx_out_valid) else $error("reset state wrong");
  chk_count_zeros: assert property (reg_rd && reg_addr == sfc_pkg::REG_COUNT |=>
    (reg_rdata & 16'he0e0) == 16'h0000) else $error("count reserved bits set");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_cts_gates: assert property (s_cts_off [*5] |-> !tx_out_valid)
    else $error("tx word offered while cts off");
  chk_rts_off: assert property (!ctl_r[3] [*2] |-> !rts_n_pin)
    else $error("rts not held low");
  chk_tx_flush: assert property (ctl_r[2] [*2] |-> !tx_in_ready && !tx_out_valid)
    else $error("tx fifo not empty in flush");
  chk_rx_flush: assert property (ctl_r[1] [*2] |-> !rx_in_ready && !rx_out_valid)
    else $error("rx fifo not empty in flush");
  chk_loop_back: assert property (s_loop_on |-> rx_serial == $past(tx_serial) && txd_pin)
    else $error("loop path wrong");
  chk_loop_off: assert property (!ctl_r[0] [*2] |-> txd_pin == $past(tx_serial))
    else $error("txd not following stream");
endmodule : sfc_serial_fifo_ctrl_monitor
bind sfc_serial_fifo_ctrl sfc_serial_fifo_ctrl_monitor i_sfc_serial_fifo_ctrl_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .rx_in_ready(rx_in_ready),
  .rx_out_valid(rx_out_valid), .tx_serial(tx_serial), .rx_serial(rx_serial),
  .txd_pin(txd_pin), .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin));
`default_nettype wire

// file: verif/sfc_serial_fifo_ctrl_tb.sv
// sfc_serial_fifo_ctrl_tb: self-checking bench for the fifo control block.
// assumes the package, stream interface, fifo, buffer and station compile first.
`timescale 1ns/1ns
`default_nettype none
module sfc_serial_fifo_ctrl_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, sync_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic reg_addr = 1'b0, tx_in_valid = 1'b0, tx_out_ready = 1'b0, tx_serial = 1'b1;
  logic rx_in_valid = 1'b0, rx_out_ready = 1'b0, busy = 1'b0, line_bit = 1'b1;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  logic [7:0] tx_in_data = 8'h00, rx_in_data = 8'h00, tx_out_data, rx_out_data;
  logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid, rx_serial, txd_pin;
  logic rxd_pin, cts_n_pin, rts_n_pin, rx_level_reached_flag;
  int errors = 0, num_checks = 0, n;
  always #4 ref_clk = ~ref_clk;
  sfc_serial_fifo_ctrl i_sfc_serial_fifo_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .sync_mode(sync_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_out_data(tx_out_data), .tx_serial(tx_serial),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
    .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data),
    .rx_serial(rx_serial), .txd_pin(txd_pin), .rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin),
    .rts_n_pin(rts_n_pin), .rx_level_reached_flag(rx_level_reached_flag));
  sfc_remote_station i_sfc_remote_station (.ref_clk(ref_clk), .busy(busy),
    .line_bit(line_bit), .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin), .rxd_pin(rxd_pin));
  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk1(input string nm, input logic e, input logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chk1
  // every task starts and ends just after a rising edge
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic wr(input logic a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    idle(1);
    reg_wr = 1'b0;
    idle(1);
  endtask : wr
  task automatic rd(input logic a, output logic [15:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    idle(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    idle(1);
  endtask : rd
  // ready is looked at before valid rises, so a refused word is never taken
  task automatic push(input bit tx, input int mx, output int k);
    k = 0;
    while (k < mx && (tx ? tx_in_ready : rx_in_ready) === 1'b1) begin
      tx_in_valid = tx;
      rx_in_valid = !tx;
      tx_in_data = k[7:0];
      rx_in_data = k[7:0];
      idle(1);
      k++;
    end
    tx_in_valid = 1'b0;
    rx_in_valid = 1'b0;
    idle(1);
  endtask : push
  // receiver stalls every other cycle while draining
  task automatic drain(input bit tx, input int cnt);
    int k;
    k = 0;
    for (int c = 0; c < 100; c++) begin
      tx_out_ready = tx & c[0];
      rx_out_ready = !tx & c[0];
      if (c[0] && (tx ? tx_out_valid : rx_out_valid) === 1'b1) begin
        chk16("word", {8'h00, k[7:0]}, {8'h00, tx ? tx_out_data : rx_out_data});
        k++;
      end
      idle(1);
    end
    tx_out_ready = 1'b0;
    rx_out_ready = 1'b0;
    chk16("words", cnt[15:0], k[15:0]);
  endtask : drain
  task automatic t_reset_values;
    rd(sfc_pkg::REG_CONTROL, v);
    chk16("control", 16'h0000, v);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("count", 16'h0000, v);
  endtask : t_reset_values
  task automatic t_flow;
    busy = 1'b1;
    wr(sfc_pkg::REG_CONTROL, 16'h0008);
    idle(6);
    push(1'b1, 40, n);
    chk16("tx pushes", 16'd18, n[15:0]);
    chk1("tx offered", 1'b0, tx_out_valid);
    push(1'b0, 40, n);
    chk16("rx pushes", 16'd18, n[15:0]);
    idle(3);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("count full", 16'h1010, v);
    chk1("rts", 1'b1, rts_n_pin);
    wr(sfc_pkg::REG_COUNT, 16'hffff);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("count written", 16'h1010, v);
    drain(1'b0, 18);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("rx drained", 16'h1000, v);
    wr(sfc_pkg::REG_CONTROL, 16'h0000);
    idle(2);
    chk1("rts off", 1'b0, rts_n_pin);
    drain(1'b1, 18);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("tx drained", 16'h0000, v);
    busy = 1'b0;
  endtask : t_flow
  task automatic t_flush;
    push(1'b1, 5, n);
    push(1'b0, 5, n);
    wr(sfc_pkg::REG_CONTROL, 16'h0006);
    idle(2);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("count flushed", 16'h0000, v);
    rd(sfc_pkg::REG_CONTROL, v);
    chk16("control flush", 16'h0006, v);
    chk1("tx ready", 1'b0, tx_in_ready);
    chk1("rx ready", 1'b0, rx_in_ready);
    wr(sfc_pkg::REG_CONTROL, 16'h0000);
    idle(4);
    chk1("tx left", 1'b0, tx_out_valid);
    chk1("rx left", 1'b0, rx_out_valid);
  endtask : t_flush
  task automatic t_trigger;
    wr(sfc_pkg::REG_CONTROL, 16'h0040);
    sync_mode = 1'b1;
    push(1'b0, 4, n);
    idle(6);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("rx held", 16'h0002, v);
    chk1("flag at level", 1'b0, rx_level_reached_flag);
    push(1'b0, 1, n);
    idle(3);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("rx above", 16'h0003, v);
    chk1("flag sync", 1'b1, rx_level_reached_flag);
    sync_mode = 1'b0;
    idle(2);
    chk1("flag async", 1'b0, rx_level_reached_flag);
    wr(sfc_pkg::REG_CONTROL, 16'h0002);
    wr(sfc_pkg::REG_CONTROL, 16'h0000);
  endtask : t_trigger
  task automatic t_loop;
    for (int m = 1; m >= 0; m--) begin
      wr(sfc_pkg::REG_CONTROL, {15'h0000, m[0]});
      for (int b = 0; b < 2; b++) begin
        tx_serial = b[0];
        line_bit = ~b[0];
        idle(8);
        chk1("rx stream", m[0] ? b[0] : ~b[0], rx_serial);
        chk1("txd", m[0] | b[0], txd_pin);
      end
    end
  endtask : t_loop
  task automatic t_reset_mid;
    push(1'b0, 3, n);
    push(1'b1, 3, n);
    wr(sfc_pkg::REG_CONTROL, 16'h0009);
    rst_n = 1'b0;
    idle(4);
    rst_n = 1'b1;
    rd(sfc_pkg::REG_CONTROL, v);
    chk16("control again", 16'h0000, v);
    rd(sfc_pkg::REG_COUNT, v);
    chk16("count again", 16'h0000, v);
    chk1("rx out again", 1'b0, rx_out_valid);
    chk1("tx out again", 1'b0, tx_out_valid);
  endtask : t_reset_mid
  // main sequence, reset held for four edges
  initial begin
    idle(4);
    rst_n = 1'b1;
    t_reset_values;
    t_flow;
    t_flush;
    t_trigger;
    t_loop;
    t_reset_mid;
    test_done;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    test_done;
  end
endmodule : sfc_serial_fifo_ctrl_tb
`default_nettype wire
